//--- include/cogp_regs.svh
`ifndef COGP_REGS_SVH
`define COGP_REGS_SVH

// System clock rate and the nanoseconds that one clock period adds to a time count.
`define COGP_CLK_HZ 200000000
`define COGP_NS_PER_SEC 1000000000
`define COGP_NS_PER_CLK (`COGP_NS_PER_SEC / `COGP_CLK_HZ)

// Register word indices on the Avalon-MM slave (byte address is four times the index).
`define COGP_REG_CTRL 4'h0
`define COGP_REG_MASK 4'h1
`define COGP_REG_STATUS 4'h2
`define COGP_REG_LENGTH 4'h3
`define COGP_REG_GROUP 4'h4

// Field positions inside the registers.
`define COGP_CTRL_START 0
`define COGP_STAT_BUSY 0
`define COGP_STAT_SYNC 1

// Reset values and fixed contents.
`define COGP_MASK_RESET 16'h0000
`define COGP_MASK_WRITABLE 16'h7FFF
`define COGP_GROUP_SEL 8'h01

// Field count, payload span and the byte size of each field in mask bit order.
`define COGP_FIELD_COUNT 15
`define COGP_PAYLOAD_MAX 198
`define COGP_SNAP_BITS 1584
`define COGP_SZ_TIME_UP 8'h08
`define COGP_SZ_SAT_TIME 8'h08
`define COGP_SZ_SYNC_TIME 8'h08
`define COGP_SZ_YPR 8'h0C
`define COGP_SZ_QUAT 8'h10
`define COGP_SZ_RATE 8'h0C
`define COGP_SZ_POS 8'h18
`define COGP_SZ_VEL 8'h0C
`define COGP_SZ_ACCEL 8'h0C
`define COGP_SZ_IMU 8'h18
`define COGP_SZ_MAGNETIC_TEMP_PRESSURE 8'h14
`define COGP_SZ_DELTA 8'h1C
`define COGP_SZ_NAV_STATUS 8'h02
`define COGP_SZ_SYNC_COUNT 8'h04
`define COGP_SZ_PPS_TIME 8'h08

`endif

//--- include/cogp_pkg.sv
package cogp_pkg;
`include "cogp_regs.svh"

   typedef enum logic [1:0] {
      COGP_IDLE = 2'b00,
      COGP_SEND = 2'b01
   } cogp_state_e;

   typedef logic [7:0] cogp_len_t;

   // Byte size of the field enabled by mask bit idx; the reserved bit has none.
   function automatic cogp_len_t cogp_field_size(input logic [3:0] idx);
      case (idx)
         4'h0: cogp_field_size = `COGP_SZ_TIME_UP;
         4'h1: cogp_field_size = `COGP_SZ_SAT_TIME;
         4'h2: cogp_field_size = `COGP_SZ_SYNC_TIME;
         4'h3: cogp_field_size = `COGP_SZ_YPR;
         4'h4: cogp_field_size = `COGP_SZ_QUAT;
         4'h5: cogp_field_size = `COGP_SZ_RATE;
         4'h6: cogp_field_size = `COGP_SZ_POS;
         4'h7: cogp_field_size = `COGP_SZ_VEL;
         4'h8: cogp_field_size = `COGP_SZ_ACCEL;
         4'h9: cogp_field_size = `COGP_SZ_IMU;
         4'hA: cogp_field_size = `COGP_SZ_MAGNETIC_TEMP_PRESSURE;
         4'hB: cogp_field_size = `COGP_SZ_DELTA;
         4'hC: cogp_field_size = `COGP_SZ_NAV_STATUS;
         4'hD: cogp_field_size = `COGP_SZ_SYNC_COUNT;
         4'hE: cogp_field_size = `COGP_SZ_PPS_TIME;
         default: cogp_field_size = 8'h00;
      endcase
   endfunction

   // Byte offset of a field inside the snapshot, the sum of all sizes below it.
   function automatic cogp_len_t cogp_field_base(input logic [3:0] idx);
      cogp_len_t base;
      base = 8'h00;
      for (int j = 0; j < `COGP_FIELD_COUNT; j++) begin
         if (j < int'(idx)) begin
            base = base + cogp_field_size(4'(j));
         end
      end
      cogp_field_base = base;
   endfunction

endpackage

//--- design/cogp_len_calc.sv
`timescale 1ns/100ps
`include "cogp_regs.svh"

module cogp_len_calc
   import cogp_pkg::*;
(
   // Field selection.
   input wire logic [15:0] field_mask,
   // Resulting payload length in bytes.
   output cogp_len_t payload_len
);

   // Every field has a fixed size, so the length is a plain sum over enabled bits.
   always_comb begin
      payload_len = 8'h00;
      for (int i = 0; i < `COGP_FIELD_COUNT; i++) begin
         if (field_mask[i]) begin
            payload_len = payload_len + cogp_field_size(4'(i));
         end
      end
   end

endmodule

//--- design/cogp_packer.sv
`timescale 1ns/100ps
`include "cogp_regs.svh"

// What this block does
// - Mask bits 0-2 pick power-up time, satellite time, sync-input time.
// - Mask bit 3 picks yaw-pitch-roll, bit 4 picks the quaternion.
// - Mask bits 5-8 pick rotation rate, position, velocity, acceleration.
// - Mask bits 9-14 pick inertial, magnetic, delta, status, sync count, pps time.
// - Power-up time field counts nanoseconds since startup.
// - Satellite time is a 64-bit nanosecond count, eight payload bytes.
// - Sync-input time is a 64-bit nanosecond count since the last trigger.
// - Yaw-pitch-roll is three floats, yaw first, in degrees.
// - Quaternion is four floats with the scalar last.
// - Rotation rate is three floats, body X, Y, Z, bias removed.
// - Position is three doubles: latitude, longitude, altitude; 24 bytes.
// - Velocity is three floats ordered north, east, down.
// - Acceleration is three floats, body X, Y, Z, gravity included.
// - Each field carries the same content as its twin in other groups.
// - Only this group is produced; the group selector reads one.
// - No length travels in the header; length follows from the mask.
// - Fields have fixed sizes; payload length is their sum.
module cogp_packer
   import cogp_pkg::*;
(
   // Clock and synchronous reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Avalon-MM register slave, word addressed.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Sync-input trigger pin.
   input wire logic sync_in,
   // Time sources from the estimator side.
   input wire logic [63:0] sat_time_ns,
   input wire logic [63:0] pps_time_ns,
   // Attitude, IEEE-754 single precision bit patterns.
   input wire logic [31:0] yaw_deg,
   input wire logic [31:0] pitch_deg,
   input wire logic [31:0] roll_deg,
   input wire logic [31:0] quat_0,
   input wire logic [31:0] quat_1,
   input wire logic [31:0] quat_2,
   input wire logic [31:0] quat_scalar,
   // Compensated rotation rate, body axes.
   input wire logic [31:0] rate_x,
   input wire logic [31:0] rate_y,
   input wire logic [31:0] rate_z,
   // Position, IEEE-754 double precision bit patterns.
   input wire logic [63:0] lat_deg,
   input wire logic [63:0] lon_deg,
   input wire logic [63:0] alt_m,
   // Velocity, north-east-down.
   input wire logic [31:0] vel_n,
   input wire logic [31:0] vel_e,
   input wire logic [31:0] vel_d,
   // Acceleration, body axes.
   input wire logic [31:0] accel_x,
   input wire logic [31:0] accel_y,
   input wire logic [31:0] accel_z,
   // Later fields, passed through as preformatted little-endian byte images.
   input wire logic [191:0] inertial_data,
   input wire logic [159:0] magnetic_temp_pressure,
   input wire logic [223:0] delta_angle_velocity,
   input wire logic [15:0] navigation_status,
   // Payload byte stream toward the packet transport.
   output logic pkt_valid,
   output logic [7:0] pkt_data,
   output logic pkt_last,
   input wire logic pkt_ready
);

   logic [63:0] time_since_power_up;
   logic [63:0] time_since_sync_input;
   logic [31:0] sync_input_count;
   logic [2:0] sync_ff;
   logic sync_level, sync_edge, sync_seen;
   logic bus_ack, wr_strobe;
   logic [15:0] field_mask, sel_mask;
   cogp_len_t payload_len, bytes_left, byt, cur_size, byte_addr;
   logic [3:0] fld;
   logic cur_on, start_req, start_go, can_load, load, busy;
   cogp_state_e state;
   logic [`COGP_SNAP_BITS-1:0] flat, snap;
   logic [31:0] next_readdata;

   // Free-running nanosecond clock from reset; each cycle adds one period.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         time_since_power_up <= 64'h0;
      end else begin
         time_since_power_up <= time_since_power_up + 64'(`COGP_NS_PER_CLK);
      end
   end

   // Three-stage synchroniser; a level counts once stages two and three agree.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync_ff <= 3'h0;
         sync_level <= 1'b0;
      end else begin
         sync_ff <= {sync_ff[1:0], sync_in};
         if (sync_ff[1] == sync_ff[2]) begin
            sync_level <= sync_ff[2];
         end
      end
   end

   assign sync_edge = sync_ff[1] & sync_ff[2] & ~sync_level;

   // Time since the last trigger restarts at each accepted rising edge.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         time_since_sync_input <= 64'h0;
         sync_input_count <= 32'h0;
      end else if (sync_edge) begin
         time_since_sync_input <= 64'h0;
         sync_input_count <= sync_input_count + 32'h1;
      end else begin
         time_since_sync_input <= time_since_sync_input + 64'(`COGP_NS_PER_CLK);
      end
   end

   // Sticky trigger flag; a new edge in the clearing cycle wins over the clear.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync_seen <= 1'b0;
      end else if (sync_edge) begin
         sync_seen <= 1'b1;
      end else if (wr_strobe && avs_address == `COGP_REG_STATUS && avs_byteenable[0] &&
                   avs_writedata[`COGP_STAT_SYNC]) begin
         sync_seen <= 1'b0;
      end
   end

   // Every access waits exactly one cycle so that read data come from a flop.
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
   assign wr_strobe = avs_write & bus_ack;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= (avs_read | avs_write) & ~bus_ack;
      end
   end

   // Read multiplexer; unmapped words read as zero.
   always_comb begin
      case (avs_address)
         `COGP_REG_MASK: next_readdata = {16'h0000, field_mask};
         `COGP_REG_STATUS: next_readdata = {30'h0, sync_seen, busy};
         `COGP_REG_LENGTH: next_readdata = {24'h000000, payload_len};
         `COGP_REG_GROUP: next_readdata = {24'h000000, `COGP_GROUP_SEL};
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !bus_ack) begin
         avs_readdata <= next_readdata;
      end
   end

   // Field mask; the reserved top bit is not stored, so a stray one cannot select.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         field_mask <= `COGP_MASK_RESET;
      end else if (wr_strobe && avs_address == `COGP_REG_MASK) begin
         if (avs_byteenable[0]) begin
            field_mask[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            field_mask[15:8] <= avs_writedata[15:8] & 8'(`COGP_MASK_WRITABLE >> 8);
         end
      end
   end

   // Fixed-size fields make the length a pure function of the mask.
   cogp_len_calc u_len (
      .field_mask(field_mask),
      .payload_len(payload_len)
   );

   // Snapshot image in mask bit order, each value little-endian within its bytes.
   // Content is the same value that feeds the matching field of the other groups.
   assign flat = {
      pps_time_ns,
      sync_input_count,
      navigation_status,
      delta_angle_velocity,
      magnetic_temp_pressure,
      inertial_data,
      accel_z, accel_y, accel_x,
      vel_d, vel_e, vel_n,
      alt_m, lon_deg, lat_deg,
      rate_z, rate_y, rate_x,
      quat_scalar, quat_2, quat_1, quat_0,
      roll_deg, pitch_deg, yaw_deg,
      time_since_sync_input,
      sat_time_ns,
      time_since_power_up
   };

   // A start while a payload is still in flight is ignored rather than queued.
   assign start_req = wr_strobe && avs_address == `COGP_REG_CTRL && avs_byteenable[0] &&
                      avs_writedata[`COGP_CTRL_START];
   assign start_go = start_req && state == COGP_IDLE && !pkt_valid;
   assign busy = (state != COGP_IDLE) | pkt_valid;

   // Current field decode.
   assign cur_size = cogp_field_size(fld);
   assign cur_on = sel_mask[fld];
   assign byte_addr = cogp_field_base(fld) + byt;
   assign can_load = ~pkt_valid | pkt_ready;
   assign load = state == COGP_SEND && bytes_left != 8'h00 && cur_on && can_load;

   // Capture all measurements at once so a payload never mixes two epochs.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         snap <= '0;
         sel_mask <= 16'h0000;
      end else if (start_go) begin
         snap <= flat;
         sel_mask <= field_mask;
      end
   end

   // Walk the fields upward; disabled fields cost one cycle and emit nothing.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= COGP_IDLE;
         fld <= 4'h0;
         byt <= 8'h00;
         bytes_left <= 8'h00;
      end else begin
         case (state)
            COGP_IDLE: begin
               if (start_go) begin
                  state <= COGP_SEND;
                  fld <= 4'h0;
                  byt <= 8'h00;
                  bytes_left <= payload_len;
               end
            end
            COGP_SEND: begin
               if (bytes_left == 8'h00) begin
                  state <= COGP_IDLE;
               end else if (!cur_on) begin
                  fld <= fld + 4'h1;
               end else if (can_load) begin
                  bytes_left <= bytes_left - 8'h01;
                  if (byt == cur_size - 8'h01) begin
                     fld <= fld + 4'h1;
                     byt <= 8'h00;
                  end else begin
                     byt <= byt + 8'h01;
                  end
               end
            end
            default: begin
               state <= COGP_IDLE;
            end
         endcase
      end
   end

   // Output byte register; the low byte of each value leaves first.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pkt_data <= 8'h00;
         pkt_last <= 1'b0;
      end else if (load) begin
         pkt_data <= snap[{byte_addr, 3'b000} +: 8];
         pkt_last <= bytes_left == 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pkt_valid <= 1'b0;
      end else if (load) begin
         pkt_valid <= 1'b1;
      end else if (pkt_ready) begin
         pkt_valid <= 1'b0;
      end
   end

   property p_time_step;
      @(posedge sys_clk) disable iff (srst)
         !$past(srst) |->
            time_since_power_up == $past(time_since_power_up) + 64'(`COGP_NS_PER_CLK);
   endproperty
   a_time_step: assert property (p_time_step) else $error("power-up time step wrong");

   property p_sync_restart;
      @(posedge sys_clk) disable iff (srst)
         sync_edge |=> time_since_sync_input == 64'h0 ##1
            time_since_sync_input == 64'(`COGP_NS_PER_CLK) || sync_edge;
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("sync time not restarted");

   property p_sync_count;
      @(posedge sys_clk) disable iff (srst)
         sync_edge |=> sync_input_count == $past(sync_input_count) + 32'h1;
   endproperty
   a_sync_count: assert property (p_sync_count) else $error("sync count not advanced");

   property p_len_loaded;
      @(posedge sys_clk) disable iff (srst)
         start_go |=> state == COGP_SEND && bytes_left == $past(payload_len);
   endproperty
   a_len_loaded: assert property (p_len_loaded) else $error("payload length not loaded");

   property p_last_byte;
      @(posedge sys_clk) disable iff (srst)
         load |=> pkt_valid && (pkt_last == ($past(bytes_left) == 8'h01));
   endproperty
   a_last_byte: assert property (p_last_byte) else $error("last flag misplaced");

   property p_skip_field;
      @(posedge sys_clk) disable iff (srst)
         state == COGP_SEND && bytes_left != 8'h00 && !cur_on |=>
            fld == $past(fld) + 4'h1 && bytes_left == $past(bytes_left);
   endproperty
   a_skip_field: assert property (p_skip_field) else $error("disabled field mishandled");

   property p_first_byte;
      @(posedge sys_clk) disable iff (srst)
         load && fld == 4'h0 && byt == 8'h00 |=> pkt_data == snap[7:0];
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("first byte not low byte");

   property p_ypr_order;
      @(posedge sys_clk) disable iff (srst)
         start_go |=> snap[24*8 +: 32] == $past(yaw_deg) && snap[32*8 +: 32] == $past(roll_deg);
   endproperty
   a_ypr_order: assert property (p_ypr_order) else $error("attitude angles misordered");

   property p_quat_scalar;
      @(posedge sys_clk) disable iff (srst)
         start_go |=> snap[48*8 +: 32] == $past(quat_scalar);
   endproperty
   a_quat_scalar: assert property (p_quat_scalar) else $error("quaternion scalar misplaced");

   property p_group_read;
      @(posedge sys_clk) disable iff (srst)
         avs_read && !bus_ack && avs_address == `COGP_REG_GROUP |=>
            !avs_waitrequest && avs_readdata == {24'h000000, `COGP_GROUP_SEL};
   endproperty
   a_group_read: assert property (p_group_read) else $error("group selector read wrong");

endmodule

//--- verif/cogp_host_sink.sv
`timescale 1ns/100ps
module cogp_host_sink (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Payload stream from the packer.
   input wire logic pkt_valid,
   input wire logic [7:0] pkt_data,
   input wire logic pkt_last,
   output logic pkt_ready,
   // Ready drops for one cycle in every stall_gap plus one; zero never stalls.
   input wire logic [3:0] stall_gap
);
   logic [3:0] cnt;
   logic [7:0] rx_q[$];
   int frames = 0;

   // Ready pattern, so that a slow parser is exercised as well as a prompt one.
   always_ff @(posedge sys_clk) begin
      cnt <= (srst || cnt >= stall_gap) ? 4'h0 : cnt + 4'h1;
      pkt_ready <= ~srst && (stall_gap == 4'h0 || cnt != stall_gap);
   end

   // No length travels with the data, so the frame ends only at the last marker.
   always @(posedge sys_clk) begin
      if (!srst && pkt_valid && pkt_ready) begin
         rx_q.push_back(pkt_data);
         if (pkt_last) frames <= frames + 1;
      end
   end
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
module tb;
   logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, sync_in;
   logic pkt_valid, pkt_last, pkt_ready;
   logic [3:0] avs_address, avs_byteenable, stall_gap;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0] pkt_data;
   logic [63:0] sat_time_ns, pps_time_ns, lat_deg, lon_deg, alt_m, tup, tsy;
   logic [31:0] yaw_deg, pitch_deg, roll_deg, quat_0, quat_1, quat_2, quat_scalar;
   logic [31:0] rate_x, rate_y, rate_z, vel_n, vel_e, vel_d, accel_x, accel_y, accel_z;
   logic [191:0] inertial_data;
   logic [159:0] magnetic_temp_pressure;
   logic [223:0] delta_angle_velocity;
   logic [15:0] navigation_status;
   int n_mismatch = 0;
   int total_checks = 0;
   int sz[15] = '{8, 8, 8, 12, 16, 12, 24, 12, 12, 24, 20, 28, 2, 4, 8};
   logic [223:0] img[15];

   cogp_packer i_cogp_packer (.*);
   cogp_host_sink i_cogp_host_sink (.*);

   // Free-running system clock at 200 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // One Avalon-MM transfer; waitrequest and read data are taken at the same rising edge.
   // A hung slave is left to the watchdog, so no wait count is assumed here.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // One idle edge, so the next call never reassigns the strobes in this step.
      @(posedge sys_clk);
   endtask

   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, {32'h0, e}, {32'h0, rd});
   endtask

   // Runs one packet and checks every byte whose content the bench can predict.
   task automatic pkt(input logic [15:0] m, input logic [3:0] gap, input logic twice);
      int ex[$];
      int f0, n;
      for (int b = 0; b < 15; b++) begin
         for (int k = 0; k < sz[b]; k++) begin
            if (m[b]) ex.push_back((b == 0 || b == 2) ? -1 : int'(img[b][8*k +: 8]));
         end
      end
      stall_gap <= gap;
      bus(1'b1, 4'h1, {16'h0, m});
      rchk("length", 4'h3, ex.size());
      i_cogp_host_sink.rx_q.delete();
      f0 = i_cogp_host_sink.frames;
      bus(1'b1, 4'h0, 32'h1);
      if (twice) bus(1'b1, 4'h0, 32'h1);
      n = 0;
      while (i_cogp_host_sink.frames == f0 && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      rchk("busy_after", 4'h2, 32'h0);
      chk("frames", 64'h1, 64'(i_cogp_host_sink.frames - f0));
      chk("rx_len", 64'(ex.size()), 64'(i_cogp_host_sink.rx_q.size()));
      for (int i = 0; i < ex.size() && i < i_cogp_host_sink.rx_q.size(); i++) begin
         if (ex[i] >= 0) chk($sformatf("byte%0d", i), 64'(ex[i]), 64'(i_cogp_host_sink.rx_q[i]));
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // A hang is cut short well past the few hundred cycles the tests take.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      end_of_test;
   end

   // Inputs get distinct patterns; the later-field images repeat one 16-bit word but differ in the low word, so a two-byte shift inside them is seen.
   initial begin
      srst = 1'b1;
      {avs_read, avs_write, sync_in} = 3'b000;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      stall_gap = 4'h0;
      sat_time_ns = 64'h1122334455667788;
      pps_time_ns = 64'h0102030405060708;
      {yaw_deg, pitch_deg, roll_deg} = {32'h422E5093, 32'h3FF13E83, 32'hBB04B548};
      {quat_0, quat_1, quat_2, quat_scalar} = {32'hA0A1A2A3, 32'hB0B1B2B3, 32'hC0C1C2C3, 32'hD0D1D2D3};
      {rate_x, rate_y, rate_z} = {32'h10203040, 32'h50607080, 32'h90A0B0C0};
      {lat_deg, lon_deg, alt_m} = {64'h4042D1E2F3A4B5C6, 64'hC05E1A2B3C4D5E6F, 64'h40590F1E2D3C4B5A};
      {vel_n, vel_e, vel_d} = {32'h3E010203, 32'h3F040506, 32'hBF070809};
      {accel_x, accel_y, accel_z} = {32'h3C0A0B0C, 32'h3D0D0E0F, 32'hC11C9D9E};
      inertial_data = {12{16'hE4C7}} ^ 192'h1;
      magnetic_temp_pressure = {10{16'h5AC3}} ^ 160'h2;
      delta_angle_velocity = {14{16'h96F1}} ^ 224'h3;
      navigation_status = 16'hBEEF;
      img[1] = 224'(sat_time_ns);
      img[3] = 224'({roll_deg, pitch_deg, yaw_deg});
      img[4] = 224'({quat_scalar, quat_2, quat_1, quat_0});
      img[5] = 224'({rate_z, rate_y, rate_x});
      img[6] = 224'({alt_m, lon_deg, lat_deg});
      img[7] = 224'({vel_d, vel_e, vel_n});
      img[8] = 224'({accel_z, accel_y, accel_x});
      img[9] = 224'(inertial_data);
      img[10] = 224'(magnetic_temp_pressure);
      img[11] = delta_angle_velocity;
      img[12] = 224'(navigation_status);
      img[13] = 224'h1;
      img[14] = 224'(pps_time_ns);
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      rchk("group", 4'h4, 32'h1);
      rchk("mask_rst", 4'h1, 32'h0);
      rchk("len_rst", 4'h3, 32'h0);
      rchk("unmapped", 4'h9, 32'h0);
      avs_byteenable <= 4'h1;
      bus(1'b1, 4'h1, 32'hFFFF);
      avs_byteenable <= 4'hF;
      rchk("mask_lane0", 4'h1, 32'h00FF);
      bus(1'b1, 4'h1, 32'hFFFF);
      rchk("mask_resv", 4'h1, 32'h7FFF);
      rchk("len_full", 4'h3, 32'd198);
      $display("test registers done");
      for (int b = 0; b < 15; b++) begin
         bus(1'b1, 4'h1, 32'h1 << b);
         rchk($sformatf("len_bit%0d", b), 4'h3, sz[b]);
      end
      $display("test field sizes done");
      pkt(16'h01F8, 4'h3, 1'b0);
      $display("test attitude and motion done");
      sync_in <= 1'b1;
      repeat (6) @(posedge sys_clk);
      sync_in <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rchk("sync_seen", 4'h2, 32'h2);
      bus(1'b1, 4'h2, 32'h2);
      rchk("sync_clear", 4'h2, 32'h0);
      pkt(16'h7E02, 4'h2, 1'b1);
      $display("test later fields done");
      pkt(16'h0005, 4'h0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         tup[8*i +: 8] = i_cogp_host_sink.rx_q[i];
         tsy[8*i +: 8] = i_cogp_host_sink.rx_q[8 + i];
      end
      chk("up_ns_step", 64'h0, tup % 5);
      chk("up_ns_nonzero", 64'h1, 64'(tup != 64'h0));
      chk("sync_below_up", 64'h1, 64'(tsy < tup));
      $display("test time fields done");
      end_of_test;
   end
endmodule
